// ---- design/rpfc_bank.sv ----
// Purpose: Protocol, FIFO threshold, packet filter and receive timer configuration bank.
// Assumes: Single clock; all inputs synchronous to clock_i.
// Notes: Register read data appear the cycle after the read strobe.
//
// Chosen here: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module rpfc_bank
	import rpfc_pkg::*;
(
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	input wire logic carrier_sense_i,
	input wire logic sync_quality_i,
	input wire logic preamble_quality_i,
	input wire logic rx_timer_start_i,
	output logic rx_timeout_o,
	output logic rx_timer_stopped_o,
	input wire logic seq_reset_cmd_i,
	input wire logic seq_advance_i,
	output logic [1:0] tx_seq_num_o,
	input wire logic [7:0] rx_fifo_level_i,
	input wire logic [7:0] tx_fifo_level_i,
	output logic fifo_almost_full_pin_o,
	output logic fifo_almost_empty_pin_o,
	input wire logic [15:0] wake_base_period_i,
	input wire logic sync_detect_i,
	output logic wake_pulse_o,
	input wire logic [14:0] backoff_seed_value_i,
	input wire logic backoff_start_i,
	output logic [14:0] backoff_random_o,
	input wire logic dual_sync_sel_i,
	input wire rpfc_pkt_s pkt_i,
	output logic pkt_accept_o,
	output logic pkt_discard_o,
	output logic ack_send_o,
	input wire logic tx_new_packet_i,
	input wire logic ack_timeout_i,
	output logic retransmit_o,
	output logic retx_exhausted_o,
	output rpfc_cfg_s cfg_o
);
	// ==========================================================
	// Register storage
	// ==========================================================
	logic [7:0] timeout_ldc_ctrl;
	logic [7:0] access_ctrl;
	logic [7:0] ack_retx_ctrl;
	logic [6:0] rx_almost_full_level;
	logic [6:0] rx_almost_empty_level;
	logic [6:0] tx_almost_full_level;
	logic [6:0] tx_almost_empty_level;
	logic [7:0] filter_options;
	logic [7:0] source_address_mask;
	logic [7:0] goal [4];
	logic [7:0] rx_timeout_count;
	logic [7:0] rx_timeout_prescale;

	function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
		hit = (addr == ofs);
	endfunction : hit

	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			timeout_ldc_ctrl <= RST_TIMEOUT_LDC;
			access_ctrl <= RST_ACCESS;
			ack_retx_ctrl <= RST_ACK_RETX;
			filter_options <= RST_FILTER_OPT;
			source_address_mask <= RST_GOAL;
			rx_timeout_count <= RST_RX_TMR_COUNT;
			rx_timeout_prescale <= RST_RX_TMR_PRESC;
		end else if (reg_wr_i) begin
			if (hit(reg_addr_i, OFS_TIMEOUT_LDC)) timeout_ldc_ctrl <= reg_wdata_i;
			if (hit(reg_addr_i, OFS_ACCESS)) access_ctrl <= reg_wdata_i;
			if (hit(reg_addr_i, OFS_ACK_RETX)) ack_retx_ctrl <= reg_wdata_i & MASK_ACK_RETX;
			if (hit(reg_addr_i, OFS_FILTER_OPT)) filter_options <= reg_wdata_i & MASK_FILTER_OPT;
			if (hit(reg_addr_i, OFS_SRC_MASK)) source_address_mask <= reg_wdata_i;
			if (hit(reg_addr_i, OFS_RX_TMR_COUNT)) rx_timeout_count <= reg_wdata_i;
			if (hit(reg_addr_i, OFS_RX_TMR_PRESC)) rx_timeout_prescale <= reg_wdata_i;
		end
	end

	// Threshold registers keep bit seven reserved.
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			rx_almost_full_level <= RST_FIFO_THR;
			rx_almost_empty_level <= RST_FIFO_THR;
			tx_almost_full_level <= RST_FIFO_THR;
			tx_almost_empty_level <= RST_FIFO_THR;
		end else if (reg_wr_i) begin
			if (hit(reg_addr_i, OFS_RX_FULL_THR)) rx_almost_full_level <= reg_wdata_i[6:0];
			if (hit(reg_addr_i, OFS_RX_EMPTY_THR)) rx_almost_empty_level <= reg_wdata_i[6:0];
			if (hit(reg_addr_i, OFS_TX_FULL_THR)) tx_almost_full_level <= reg_wdata_i[6:0];
			if (hit(reg_addr_i, OFS_TX_EMPTY_THR)) tx_almost_empty_level <= reg_wdata_i[6:0];
		end
	end

	// Goal registers occupy four consecutive offsets, byte three first.
	for (genvar g = 0; g < 4; g++) begin : g_goal
		always_ff @(posedge clock_i) begin
			if (!rstn_i) begin
				goal[g] <= RST_GOAL;
			end else if (reg_wr_i && hit(reg_addr_i, OFS_GOAL0 - 8'(g))) begin
				goal[g] <= reg_wdata_i;
			end
		end
	end

	// ==========================================================
	// Read port
	// ==========================================================
	logic [7:0] read_mux;
	always_comb begin
		unique case (reg_addr_i)
			OFS_TIMEOUT_LDC: read_mux = timeout_ldc_ctrl;
			OFS_ACCESS: read_mux = access_ctrl;
			OFS_ACK_RETX: read_mux = ack_retx_ctrl;
			OFS_RX_FULL_THR: read_mux = {1'b0, rx_almost_full_level};
			OFS_RX_EMPTY_THR: read_mux = {1'b0, rx_almost_empty_level};
			OFS_TX_FULL_THR: read_mux = {1'b0, tx_almost_full_level};
			OFS_TX_EMPTY_THR: read_mux = {1'b0, tx_almost_empty_level};
			OFS_FILTER_OPT: read_mux = filter_options;
			OFS_SRC_MASK: read_mux = source_address_mask;
			OFS_GOAL3: read_mux = goal[3];
			OFS_GOAL2: read_mux = goal[2];
			OFS_GOAL1: read_mux = goal[1];
			OFS_GOAL0: read_mux = goal[0];
			OFS_RX_TMR_COUNT: read_mux = rx_timeout_count;
			OFS_RX_TMR_PRESC: read_mux = rx_timeout_prescale;
			default: read_mux = 8'h00;
		endcase
	end

	always_ff @(posedge clock_i) begin
		if (!rstn_i) reg_rdata_o <= 8'h00;
		else if (reg_rd_i) reg_rdata_o <= read_mux;
		else reg_rdata_o <= 8'h00;
	end

	// ==========================================================
	// Configuration outputs
	// ==========================================================
	logic auto_packet_filter_en;
	assign auto_packet_filter_en = access_ctrl[B_AUTO_FLT];
	always_comb begin
		cfg_o.piggyback_en = access_ctrl[B_PIGGYBACK];
		cfg_o.sniff_timer_en = access_ctrl[B_SNIFF];
		cfg_o.channel_access_en = access_ctrl[B_CSMA];
		cfg_o.channel_access_persistent_en = access_ctrl[B_CSMA_PERS];
		cfg_o.backoff_apply = access_ctrl[B_CSMA] & ~access_ctrl[B_CSMA_PERS];
		cfg_o.no_ack_request_flag = ack_retx_ctrl[B_NO_ACK];
		cfg_o.persistent_receive_en = ack_retx_ctrl[B_PERSISTENT_RECEIVE_EN];
		cfg_o.max_retransmit_count = ack_retx_ctrl[B_RETX_HI:B_RETX_LO];
		cfg_o.dual_sync_active = dual_sync_sel_i;
		cfg_o.dual_sync_word = dual_sync_sel_i ? {goal[3], goal[2], goal[1], goal[0]} : 32'h0;
	end

	// ==========================================================
	// Receive timeout stop condition and timer
	// ==========================================================
	logic [2:0] stop_en;
	logic [2:0] stop_ind;
	logic stop_cond;
	assign stop_en = timeout_ldc_ctrl[B_CS_STOP:B_PQI_STOP];
	assign stop_ind = {carrier_sense_i, sync_quality_i, preamble_quality_i};
	// With nothing enabled the timeout is never stopped, in either mode.
	assign stop_cond = (stop_en != 3'h0) && (filter_options[B_AND_OR] ?
		|(stop_en & stop_ind) : &(~stop_en | stop_ind));

	rpfc_tmr_e tmr_state;
	logic [7:0] presc_cnt;
	logic [7:0] tick_cnt;
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			tmr_state <= RPFC_TMR_IDLE;
			presc_cnt <= 8'h00;
			tick_cnt <= 8'h00;
			rx_timeout_o <= 1'b0;
			rx_timer_stopped_o <= 1'b0;
		end else begin
			rx_timeout_o <= 1'b0;
			rx_timer_stopped_o <= 1'b0;
			unique case (tmr_state)
				RPFC_TMR_IDLE: begin
					// A zero count leaves the receiver without a timeout.
					if (rx_timer_start_i && rx_timeout_count != 8'h00) begin
						tmr_state <= RPFC_TMR_RUN;
						presc_cnt <= 8'h00;
						tick_cnt <= 8'h00;
					end
				end
				RPFC_TMR_RUN: begin
					if (stop_cond) begin
						tmr_state <= RPFC_TMR_IDLE;
						rx_timer_stopped_o <= 1'b1;
					end else if (presc_cnt == rx_timeout_prescale) begin
						presc_cnt <= 8'h00;
						if (tick_cnt == rx_timeout_count - 8'h01) begin
							tmr_state <= RPFC_TMR_IDLE;
							rx_timeout_o <= 1'b1;
						end
						tick_cnt <= tick_cnt + 8'h01;
					end else begin
						presc_cnt <= presc_cnt + 8'h01;
					end
				end
			endcase
		end
	end

	// ==========================================================
	// Sequence number, FIFO level pin
	// ==========================================================
	always_ff @(posedge clock_i) begin
		if (!rstn_i) tx_seq_num_o <= 2'h0;
		else if (seq_reset_cmd_i) tx_seq_num_o <= timeout_ldc_ctrl[B_SEQ_HI:B_SEQ_LO];
		else if (seq_advance_i) tx_seq_num_o <= tx_seq_num_o + 2'h1;
	end

	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			fifo_almost_full_pin_o <= 1'b0;
			fifo_almost_empty_pin_o <= 1'b0;
		end else if (timeout_ldc_ctrl[B_FIFO_SEL]) begin
			fifo_almost_full_pin_o <= tx_fifo_level_i >= {1'b0, tx_almost_full_level};
			fifo_almost_empty_pin_o <= tx_fifo_level_i <= {1'b0, tx_almost_empty_level};
		end else begin
			fifo_almost_full_pin_o <= rx_fifo_level_i >= {1'b0, rx_almost_full_level};
			fifo_almost_empty_pin_o <= rx_fifo_level_i <= {1'b0, rx_almost_empty_level};
		end
	end

	// ==========================================================
	// Low duty cycle wake timer
	// ==========================================================
	logic [18:0] wake_period;
	logic [18:0] wake_cnt;
	assign wake_period = {3'h0, wake_base_period_i} << timeout_ldc_ctrl[B_MULT_HI:B_MULT_LO];
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			wake_cnt <= 19'h0;
			wake_pulse_o <= 1'b0;
		end else if (!access_ctrl[B_LDC_EN]) begin
			wake_cnt <= 19'h0;
			wake_pulse_o <= 1'b0;
		end else if (access_ctrl[B_LDC_RELOAD] && sync_detect_i) begin
			wake_cnt <= 19'h0;
			wake_pulse_o <= 1'b0;
		end else if (wake_cnt + 19'h1 >= wake_period) begin
			wake_cnt <= 19'h0;
			wake_pulse_o <= 1'b1;
		end else begin
			wake_cnt <= wake_cnt + 19'h1;
			wake_pulse_o <= 1'b0;
		end
	end

	// ==========================================================
	// Back-off random generator
	// ==========================================================
	always_ff @(posedge clock_i) begin
		if (!rstn_i) backoff_random_o <= 15'h0001;
		else if (backoff_start_i && access_ctrl[B_SEED_RELOAD])
			backoff_random_o <= backoff_seed_value_i;
		else
			backoff_random_o <= {backoff_random_o[13:0], ^(backoff_random_o & LFSR_TAPS)};
	end

	// ==========================================================
	// Received packet filter and acknowledgment
	// ==========================================================
	logic addr_any_en;
	logic addr_ok;
	logic src_ok;
	logic crc_ok;
	logic accept;
	assign addr_any_en = |filter_options[B_BCAST_FLT:B_OWN_FLT];
	assign addr_ok = !addr_any_en || dual_sync_sel_i
		|| (filter_options[B_BCAST_FLT] && pkt_i.dest == goal[2])
		|| (filter_options[B_MCAST_FLT] && pkt_i.dest == goal[1])
		|| (filter_options[B_OWN_FLT] && pkt_i.dest == goal[3]);
	assign src_ok = !filter_options[B_SRC_FLT] || dual_sync_sel_i
		|| ((pkt_i.source & source_address_mask) == (goal[3] & source_address_mask));
	assign crc_ok = !filter_options[B_BAD_CHECK_DISCARD_EN] || pkt_i.crc_ok;
	assign accept = !auto_packet_filter_en || (addr_ok && src_ok && crc_ok);

	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			pkt_accept_o <= 1'b0;
			pkt_discard_o <= 1'b0;
			ack_send_o <= 1'b0;
		end else begin
			pkt_accept_o <= pkt_i.valid && accept;
			pkt_discard_o <= pkt_i.valid && !accept;
			ack_send_o <= pkt_i.valid && accept && pkt_i.ack_req && ack_retx_ctrl[B_AUTO_ACK];
		end
	end

	// ==========================================================
	// Retransmission counter
	// ==========================================================
	logic [3:0] retx_cnt;
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			retx_cnt <= 4'h0;
			retransmit_o <= 1'b0;
			retx_exhausted_o <= 1'b0;
		end else if (tx_new_packet_i) begin
			retx_cnt <= 4'h0;
			retransmit_o <= 1'b0;
			retx_exhausted_o <= 1'b0;
		end else if (ack_timeout_i) begin
			if (retx_cnt < ack_retx_ctrl[B_RETX_HI:B_RETX_LO]) begin
				retx_cnt <= retx_cnt + 4'h1;
				retransmit_o <= 1'b1;
			end else begin
				retransmit_o <= 1'b0;
				retx_exhausted_o <= 1'b1;
			end
		end else begin
			retransmit_o <= 1'b0;
		end
	end

	// ==========================================================
	// Checks
	// ==========================================================
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rstn_i);

	AST_STOP_NONE_ENABLED: assert property (
		(tmr_state == RPFC_TMR_RUN && stop_en == 3'h0) |=> !rx_timer_stopped_o)
		else $error("Timeout stopped with no source enabled.");
	AST_STOP_OR_MODE: assert property (
		(tmr_state == RPFC_TMR_RUN && filter_options[B_AND_OR] && (stop_en & stop_ind) != 3'h0)
		|=> rx_timer_stopped_o && tmr_state == RPFC_TMR_IDLE)
		else $error("OR combination failed to stop timeout.");
	AST_SEQ_RELOAD: assert property (
		seq_reset_cmd_i |=> tx_seq_num_o == $past(timeout_ldc_ctrl[B_SEQ_HI:B_SEQ_LO]))
		else $error("Sequence counter did not load reload value.");
	AST_WAKE_OFF: assert property (
		!access_ctrl[B_LDC_EN] |=> !wake_pulse_o) else $error("Wake pulse outside low duty cycle.");
	AST_SEED_LOAD: assert property (
		(backoff_start_i && access_ctrl[B_SEED_RELOAD]) |=> backoff_random_o == $past(backoff_seed_value_i))
		else $error("Back-off seed not reloaded.");
	AST_NO_RETX_ZERO: assert property (
		(ack_retx_ctrl[B_RETX_HI:B_RETX_LO] == 4'h0 && !tx_new_packet_i) |=> !retransmit_o)
		else $error("Retransmission with zero limit.");
	AST_CRC_DISCARD: assert property (
		(pkt_i.valid && !pkt_i.crc_ok && filter_options[B_BAD_CHECK_DISCARD_EN] && auto_packet_filter_en)
		|=> pkt_discard_o && !pkt_accept_o) else $error("Bad CRC packet not discarded.");
	AST_PASS_UNFILTERED: assert property (
		(pkt_i.valid && !auto_packet_filter_en) |=> pkt_accept_o && !pkt_discard_o)
		else $error("Packet refused with filtering off.");
	AST_AUTO_ACK: assert property (
		ack_send_o |-> $past(ack_retx_ctrl[B_AUTO_ACK]) && pkt_accept_o)
		else $error("Acknowledgment without enable or acceptance.");
	AST_READ_LATENCY: assert property (
		(reg_rd_i && reg_addr_i == OFS_RX_TMR_COUNT && !reg_wr_i) |=> reg_rdata_o == $past(rx_timeout_count))
		else $error("Timer count readback wrong.");
endmodule : rpfc_bank
`default_nettype wire

// ---- design/rpfc_pkg.sv ----
// Purpose: Constants, field positions and carrier types of the radio protocol/filter config bank.
// Assumes: Eight-bit registers at their printed byte offsets on a plain strobe port.
// Notes: Bits not listed read as zero.
package rpfc_pkg;
	localparam logic [7:0] OFS_TIMEOUT_LDC = 8'h39;
	localparam logic [7:0] OFS_ACCESS = 8'h3A;
	localparam logic [7:0] OFS_ACK_RETX = 8'h3B;
	localparam logic [7:0] OFS_RX_FULL_THR = 8'h3C;
	localparam logic [7:0] OFS_RX_EMPTY_THR = 8'h3D;
	localparam logic [7:0] OFS_TX_FULL_THR = 8'h3E;
	localparam logic [7:0] OFS_TX_EMPTY_THR = 8'h3F;
	localparam logic [7:0] OFS_FILTER_OPT = 8'h40;
	localparam logic [7:0] OFS_SRC_MASK = 8'h41;
	localparam logic [7:0] OFS_GOAL3 = 8'h42;
	localparam logic [7:0] OFS_GOAL2 = 8'h43;
	localparam logic [7:0] OFS_GOAL1 = 8'h44;
	localparam logic [7:0] OFS_GOAL0 = 8'h45;
	localparam logic [7:0] OFS_RX_TMR_COUNT = 8'h46;
	localparam logic [7:0] OFS_RX_TMR_PRESC = 8'h47;
	localparam logic [7:0] RST_TIMEOUT_LDC = 8'h40;
	localparam logic [7:0] RST_ACCESS = 8'h00;
	localparam logic [7:0] RST_ACK_RETX = 8'h08;
	localparam logic [6:0] RST_FIFO_THR = 7'h30;
	localparam logic [7:0] RST_FILTER_OPT = 8'h40;
	localparam logic [7:0] RST_GOAL = 8'h00;
	localparam logic [7:0] RST_RX_TMR_COUNT = 8'h01;
	localparam logic [7:0] RST_RX_TMR_PRESC = 8'h00;
	// Field positions.
	localparam int B_CS_STOP = 7;
	localparam int B_SQI_STOP = 6;
	localparam int B_PQI_STOP = 5;
	localparam int B_SEQ_HI = 4;
	localparam int B_SEQ_LO = 3;
	localparam int B_FIFO_SEL = 2;
	localparam int B_MULT_HI = 1;
	localparam int B_MULT_LO = 0;
	localparam int B_LDC_EN = 7;
	localparam int B_LDC_RELOAD = 6;
	localparam int B_PIGGYBACK = 5;
	localparam int B_SNIFF = 4;
	localparam int B_SEED_RELOAD = 3;
	localparam int B_CSMA = 2;
	localparam int B_CSMA_PERS = 1;
	localparam int B_AUTO_FLT = 0;
	localparam int B_RETX_HI = 7;
	localparam int B_RETX_LO = 4;
	localparam int B_NO_ACK = 3;
	localparam int B_AUTO_ACK = 2;
	localparam int B_PERSISTENT_RECEIVE_EN = 1;
	localparam int B_AND_OR = 6;
	localparam int B_SRC_FLT = 4;
	localparam int B_BCAST_FLT = 3;
	localparam int B_MCAST_FLT = 2;
	localparam int B_OWN_FLT = 1;
	localparam int B_BAD_CHECK_DISCARD_EN = 0;
	localparam logic [7:0] MASK_ACK_RETX = 8'hFE;
	localparam logic [7:0] MASK_FILTER_OPT = 8'h5F;
	localparam logic [14:0] LFSR_TAPS = 15'h6000;

	typedef struct packed {
		logic piggyback_en;
		logic sniff_timer_en;
		logic channel_access_en;
		logic channel_access_persistent_en;
		logic backoff_apply;
		logic no_ack_request_flag;
		logic persistent_receive_en;
		logic [3:0] max_retransmit_count;
		logic [31:0] dual_sync_word;
		logic dual_sync_active;
	} rpfc_cfg_s;

	typedef struct packed {
		logic valid;
		logic [7:0] source;
		logic [7:0] dest;
		logic crc_ok;
		logic ack_req;
	} rpfc_pkt_s;

	typedef enum logic [1:0] {
		RPFC_TMR_IDLE = 2'b01,
		RPFC_TMR_RUN = 2'b10
	} rpfc_tmr_e;
endpackage : rpfc_pkg

// ---- tb/rpfc_remote_node.sv ----
// Purpose: Model of the remote radio node that hands received packets to the bank.
// Assumes: One send request gives one packet, valid for exactly one cycle.
// Notes: Between packets the fields invert every cycle, starting from the inverse of the last packet.
`timescale 1ns/1ps
`default_nettype none
module rpfc_remote_node
	import rpfc_pkg::*;
(
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic send_i,
	input wire rpfc_pkt_s frame_i,
	output rpfc_pkt_s pkt_o
);
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			pkt_o <= '0;
		end else if (send_i) begin
			pkt_o <= {1'b1, frame_i[17:0]};
		end else begin
			pkt_o <= {1'b0, ~pkt_o[17:0]};
		end
	end
endmodule : rpfc_remote_node
`default_nettype wire

// ---- tb/testbench.sv ----
// Purpose: Self-checking bench for the protocol and filter configuration bank.
// Assumes: Strobe register port, read data one cycle after the read strobe.
// Notes: After the blocking time-zero defaults, all stimulus is applied by non-blocking assignment at the rising edge.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import rpfc_pkg::*;
	logic clock_i, rstn_i, reg_wr_i, reg_rd_i, carrier_sense_i, sync_quality_i;
	logic preamble_quality_i, rx_timer_start_i, rx_timeout_o, rx_timer_stopped_o;
	logic seq_reset_cmd_i, seq_advance_i, fifo_almost_full_pin_o, fifo_almost_empty_pin_o;
	logic sync_detect_i, wake_pulse_o, backoff_start_i, dual_sync_sel_i, pkt_accept_o;
	logic pkt_discard_o, ack_send_o, tx_new_packet_i, ack_timeout_i, retransmit_o;
	logic retx_exhausted_o, send;
	logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, rx_fifo_level_i, tx_fifo_level_i;
	logic [1:0] tx_seq_num_o;
	logic [15:0] wake_base_period_i;
	logic [14:0] backoff_seed_value_i, backoff_random_o;
	rpfc_pkt_s pkt_i, frame;
	rpfc_cfg_s cfg_o;
	int fail_count = 0;
	int tests_run = 0;
	int cyc = 0;
	int n, k;
	logic [7:0] rv [15] = '{8'h40, 8'h00, 8'h08, 8'h30, 8'h30, 8'h30, 8'h30, 8'h40,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00};
	logic [7:0] wm [15] = '{8'hFF, 8'hFF, 8'hFE, 8'h7F, 8'h7F, 8'h7F, 8'h7F, 8'h5F,
		8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
	rpfc_bank dut_u (.clock_i, .rstn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
		.reg_rdata_o, .carrier_sense_i, .sync_quality_i, .preamble_quality_i,
		.rx_timer_start_i, .rx_timeout_o, .rx_timer_stopped_o, .seq_reset_cmd_i,
		.seq_advance_i, .tx_seq_num_o, .rx_fifo_level_i, .tx_fifo_level_i,
		.fifo_almost_full_pin_o, .fifo_almost_empty_pin_o, .wake_base_period_i,
		.sync_detect_i, .wake_pulse_o, .backoff_seed_value_i, .backoff_start_i,
		.backoff_random_o, .dual_sync_sel_i, .pkt_i, .pkt_accept_o, .pkt_discard_o,
		.ack_send_o, .tx_new_packet_i, .ack_timeout_i, .retransmit_o, .retx_exhausted_o,
		.cfg_o);
	rpfc_remote_node node_u (.clock_i, .rstn_i, .send_i(send), .frame_i(frame),
		.pkt_o(pkt_i));
	// ==========================================================
	// Tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic test_done;
		if (fail_count == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : test_done
	task automatic rst;
		@(posedge clock_i) rstn_i <= 1'b0;
		repeat (5) @(posedge clock_i);
		rstn_i <= 1'b1;
	endtask : rst
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock_i) begin
			reg_addr_i <= a;
			reg_wdata_i <= d;
			reg_wr_i <= 1'b1;
		end
		@(posedge clock_i) reg_wr_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clock_i) begin
			reg_addr_i <= a;
			reg_rd_i <= 1'b1;
		end
		@(posedge clock_i) reg_rd_i <= 1'b0;
		#1 chk(32'(reg_rdata_o), 32'(e));
	endtask : rd
	// Expected bits are accept, discard, acknowledge.
	task automatic pkt(input logic [7:0] s, input logic [7:0] d, input logic ok,
		input logic [2:0] e);
		@(posedge clock_i) begin
			frame <= {1'b0, s, d, ok, 1'b1};
			send <= 1'b1;
		end
		@(posedge clock_i) send <= 1'b0;
		@(posedge clock_i) #1 chk(32'({pkt_accept_o, pkt_discard_o, ack_send_o}), 32'(e));
	endtask : pkt
	task automatic run_tmr(input logic stop, input int e);
		n = 0;
		@(posedge clock_i) rx_timer_start_i <= 1'b1;
		@(posedge clock_i) rx_timer_start_i <= 1'b0;
		do @(posedge clock_i) #1 n++; while (!rx_timeout_o && !rx_timer_stopped_o && n < 200);
		chk(32'(rx_timer_stopped_o), 32'(stop));
		if (!stop) chk(32'(n), 32'(e));
	endtask : run_tmr
	// ==========================================================
	// Clock, watchdog and main sequence
	initial begin
		clock_i = 1'b0;
		forever #2.5 clock_i = ~clock_i;
	end
	always @(posedge clock_i) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			test_done();
		end
	end
	initial begin
		{rstn_i, reg_wr_i, reg_rd_i, carrier_sense_i, sync_quality_i, preamble_quality_i} = '0;
		{rx_timer_start_i, seq_reset_cmd_i, seq_advance_i, sync_detect_i, send} = '0;
		{backoff_start_i, dual_sync_sel_i, tx_new_packet_i, ack_timeout_i} = '0;
		{reg_addr_i, reg_wdata_i, rx_fifo_level_i, tx_fifo_level_i} = '0;
		wake_base_period_i = 16'h0003;
		backoff_seed_value_i = 15'h1234;
		frame = '0;
		rst();
		for (int i = 0; i < 15; i++) rd(8'h39 + 8'(i), rv[i]);
		for (int i = 0; i < 15; i++) begin
			wr(8'h39 + 8'(i), 8'hFF);
			rd(8'h39 + 8'(i), wm[i]);
		end
		wr(8'h48, 8'hFF);
		rd(8'h48, 8'h00);
		rd(8'h38, 8'h00);
		rst();
		chk(32'(cfg_o.no_ack_request_flag), 32'h1);
		wr(8'h39, 8'h10);
		@(posedge clock_i) seq_reset_cmd_i <= 1'b1;
		@(posedge clock_i) seq_reset_cmd_i <= 1'b0;
		#1 chk(32'(tx_seq_num_o), 32'h2);
		wr(8'h3A, 8'hF6);
		#1 chk(32'({cfg_o.piggyback_en, cfg_o.sniff_timer_en, cfg_o.channel_access_en,
			cfg_o.channel_access_persistent_en, cfg_o.backoff_apply}), 32'h1E);
		wr(8'h3A, 8'h04);
		#1 chk(32'({cfg_o.channel_access_en, cfg_o.backoff_apply}), 32'h3);
		wr(8'h3B, 8'h16);
		#1 chk(32'({cfg_o.max_retransmit_count, cfg_o.no_ack_request_flag,
			cfg_o.persistent_receive_en}), 32'h5);
		@(posedge clock_i) tx_new_packet_i <= 1'b1;
		@(posedge clock_i) tx_new_packet_i <= 1'b0;
		for (int i = 0; i < 2; i++) begin
			@(posedge clock_i) ack_timeout_i <= 1'b1;
			@(posedge clock_i) ack_timeout_i <= 1'b0;
			#1 chk(32'({retransmit_o, retx_exhausted_o}), (i == 0) ? 32'h2 : 32'h1);
		end
		wr(8'h3A, 8'h00);
		wr(8'h40, 8'h43);
		wr(8'h42, 8'h5A);
		pkt(8'h00, 8'h11, 1'b0, 3'b101);
		wr(8'h3A, 8'h01);
		pkt(8'h00, 8'h5A, 1'b1, 3'b101);
		pkt(8'h00, 8'h11, 1'b1, 3'b010);
		pkt(8'h00, 8'h5A, 1'b0, 3'b010);
		wr(8'h40, 8'h50);
		wr(8'h41, 8'hF0);
		pkt(8'h53, 8'h11, 1'b1, 3'b101);
		pkt(8'h63, 8'h11, 1'b1, 3'b010);
		wr(8'h3C, 8'h10);
		wr(8'h3D, 8'h0F);
		rx_fifo_level_i <= 8'h10;
		tx_fifo_level_i <= 8'h05;
		for (int i = 0; i < 2; i++) begin
			wr(8'h39, i ? 8'h04 : 8'h00);
			repeat (2) @(posedge clock_i);
			#1 chk(32'({fifo_almost_full_pin_o, fifo_almost_empty_pin_o}), i ? 32'h1 : 32'h2);
		end
		wr(8'h46, 8'h03);
		wr(8'h47, 8'h01);
		wr(8'h39, 8'h00);
		wr(8'h40, 8'h40);
		carrier_sense_i <= 1'b1;
		run_tmr(1'b0, 6);
		wr(8'h39, 8'h80);
		run_tmr(1'b1, 0);
		wr(8'h39, 8'hA0);
		wr(8'h40, 8'h00);
		run_tmr(1'b0, 6);
		@(posedge clock_i) preamble_quality_i <= 1'b1;
		run_tmr(1'b1, 0);
		wr(8'h3A, 8'h80);
		for (int m = 0; m < 4; m++) begin
			wr(8'h39, 8'(m));
			k = 0;
			do @(posedge clock_i) #1 k++; while (!wake_pulse_o && k < 300);
			n = 0;
			do @(posedge clock_i) #1 n++; while (!wake_pulse_o && n < 300);
			chk(32'(n), 32'(3 << m));
		end
		wr(8'h3A, 8'hC8);
		@(posedge clock_i) begin
			sync_detect_i <= 1'b1;
			backoff_start_i <= 1'b1;
		end
		@(posedge clock_i) backoff_start_i <= 1'b0;
		#1 chk(32'(backoff_random_o), 32'h1234);
		k = 0;
		repeat (30) @(posedge clock_i) #1 k += int'(wake_pulse_o);
		chk(32'(k), 32'h0);
		@(posedge clock_i) sync_detect_i <= 1'b0;
		for (int i = 0; i < 4; i++) wr(8'h42 + 8'(i), 8'hA1 + 8'(8'h11 * i));
		@(posedge clock_i) dual_sync_sel_i <= 1'b1;
		@(posedge clock_i) #1 chk(cfg_o.dual_sync_word, 32'hA1B2C3D4);
		chk(32'(cfg_o.dual_sync_active), 32'h1);
		@(posedge clock_i) dual_sync_sel_i <= 1'b0;
		@(posedge clock_i) #1 chk(cfg_o.dual_sync_word, 32'h00000000);
		test_done();
	end
endmodule : testbench
`default_nettype wire
